//--- dv/fault_propagation_manager_asserts.sv
// Purpose: port checks for the group fault propagation block
// Assumes: vout_zero_i pulses only when a ramp-down or fast off ends
// Notes: bound to the top module below
`timescale 1ns/100ps
module fault_propagation_manager_asserts #(
    parameter int HICCUP_CYCLES = 2600000
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_wdata_i,
    input wire logic [7:0] cfg_rdata_o,
    input wire logic [7:0] flag_clr_i,
    input wire logic [7:0] fault_flag_n_o,
    input wire logic above_prebias_i,
    input wire logic vout_zero_i,
    input wire logic track_det_i,
    input wire logic overcurrent_det_i,
    input wire logic overvoltage_det_i,
    input wire logic group_error_i,
    input wire logic group_fault_i,
    input wire logic group_fault_o,
    input wire logic group_fault_oe_o,
    input wire logic ramp_up_o,
    input wire logic switching_en_o,
    input wire logic low_side_on_o
);
    localparam int OC = fault_prop_pkg::BIT_OC;
    logic [31:0] zero_cnt_reg, zero_cnt_next;
    // saturating count of cycles since the output last reached zero
    always_comb begin
        zero_cnt_next = zero_cnt_reg + 32'h1;
        if (vout_zero_i) begin
            zero_cnt_next = 32'h0;
        end else if (zero_cnt_reg == 32'hFFFFFFFF) begin
            zero_cnt_next = zero_cnt_reg;
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            zero_cnt_reg <= 32'hFFFFFFFF;
        end else begin
            zero_cnt_reg <= zero_cnt_next;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    a_cfg_write_lands: assert property (cfg_wr_i |=> cfg_rdata_o == $past(cfg_wdata_i))
        else $error("config readback differs from write");
    a_line_open_drain: assert property (group_fault_o == 1'b0)
        else $error("group line driven high");
    a_oc_fast_off: assert property (switching_en_o && above_prebias_i && overcurrent_det_i
        && !overvoltage_det_i |=> !switching_en_o && !low_side_on_o && !fault_flag_n_o[OC])
        else $error("overcurrent did not give fast off");
    a_ov_low_side: assert property (switching_en_o && above_prebias_i && overvoltage_det_i
        |=> !switching_en_o && low_side_on_o ##1 low_side_on_o)
        else $error("overvoltage did not turn low side on");
    a_oc_prop_drives: assert property (switching_en_o && above_prebias_i && overcurrent_det_i
        && cfg_rdata_o[OC] |=> group_fault_oe_o)
        else $error("enabled fault not pulled onto group line");
    a_flag_holds_low: assert property (!fault_flag_n_o[OC] && !flag_clr_i[OC]
        |=> !fault_flag_n_o[OC])
        else $error("status flag restored without clear");
    a_peer_error_fast: assert property (ramp_up_o && !group_fault_oe_o && !group_fault_i
        && group_error_i && !overvoltage_det_i |=> !switching_en_o && !low_side_on_o)
        else $error("received error did not give fast off");
    a_peer_fault_ramped: assert property (ramp_up_o && !group_fault_oe_o && !group_fault_i
        && !group_error_i && !track_det_i && !overcurrent_det_i && !overvoltage_det_i
        |=> switching_en_o [*2])
        else $error("received fault did not give regular off");
    a_hiccup_gap: assert property ($rose(ramp_up_o) |-> zero_cnt_reg >= 32'(HICCUP_CYCLES - 2))
        else $error("restart sooner than hiccup interval");
endmodule // fault_propagation_manager_asserts

bind fault_propagation_manager fault_propagation_manager_asserts #(
    .HICCUP_CYCLES(HICCUP_CYCLES)
) u_asserts (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cfg_wr_i(cfg_wr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .flag_clr_i(flag_clr_i),
    .fault_flag_n_o(fault_flag_n_o), .above_prebias_i(above_prebias_i),
    .vout_zero_i(vout_zero_i), .track_det_i(track_det_i),
    .overcurrent_det_i(overcurrent_det_i), .overvoltage_det_i(overvoltage_det_i),
    .group_error_i(group_error_i), .group_fault_i(group_fault_i),
    .group_fault_o(group_fault_o), .group_fault_oe_o(group_fault_oe_o),
    .ramp_up_o(ramp_up_o), .switching_en_o(switching_en_o), .low_side_on_o(low_side_on_o)
);

//--- dv/fault_propagation_manager_bench.sv
// Purpose: directed test of group fault propagation and hiccup restart
// Assumes: inputs change at the falling edge
// Notes: hiccup shortened to HC cycles
`timescale 1ns/100ps
module fault_propagation_manager_bench;
    localparam int HC = 50;
    logic clk_sys_i = 1'h0, resetn_i = 1'h0, cfg_wr_i = 1'h0, track_en_i = 1'h0;
    logic [7:0] cfg_wdata_i = 8'h00, flag_clr_i = 8'h00, cfg_rdata_o, fault_flag_n_o;
    logic turn_on_i = 1'h0, above_pb = 1'h0, done = 1'h0, vout_zero_i = 1'h0;
    logic trk = 1'h0, oc = 1'h0, uv = 1'h0, ov = 1'h0, peer_err = 1'h0, tw = 1'h0;
    logic [30:0] peer_pull = '0;
    logic line, gerr, gout, oe, rup, rdn, sw, low_side, fe_off, warn;
    logic [2:0] other_lines;
    int n_fail = 0, comparisons = 0, k = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    fault_propagation_manager #(.HICCUP_CYCLES(HC)) DUT (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cfg_wr_i(cfg_wr_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .flag_clr_i(flag_clr_i),
        .fault_flag_n_o(fault_flag_n_o), .latch_sel_i(5'h00), .track_en_i(track_en_i),
        .toff_delay_cyc_i(22'h000006), .turn_on_i(turn_on_i), .above_prebias_i(above_pb),
        .ramp_up_done_i(done), .vout_zero_i(vout_zero_i), .temp_warn_i(tw),
        .pgood_bad_i(1'h0), .track_det_i(trk), .overtemp_det_i(1'h0),
        .overcurrent_det_i(oc), .undervoltage_det_i(uv), .overvoltage_det_i(ov),
        .group_error_i(gerr), .group_fault_i(line), .group_fault_o(gout),
        .group_fault_oe_o(oe), .warn_report_o(warn), .ramp_up_o(rup), .ramp_down_o(rdn),
        .switching_en_o(sw), .low_side_on_o(low_side)
    );
    group_line_model u_line (
        .clk_sys_i(clk_sys_i), .dut_oe_i(oe), .peer_pull_i(peer_pull),
        .peer_error_i(peer_err), .fwd_en_i(1'h1), .line_o(line), .error_o(gerr),
        .other_lines_o(other_lines), .front_end_off_o(fe_off)
    );
    // ****************************************
    // helpers
    // ****************************************
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // task keeps the strobe up between back-to-back writes until last is set
    task automatic cfg_write(input logic [7:0] d, input logic last);
        cfg_wr_i = 1'h1;
        cfg_wdata_i = d;
        cyc(1);
        cfg_wr_i = !last;
    endtask
    task automatic wait_for(input logic dn, input int lim);
        k = 0;
        while ((dn ? rdn : rup) !== 1'h1 && k < lim) begin
            cyc(1);
            k++;
        end
        if (k >= lim) begin
            n_fail++;
            $display("MISMATCH at %0t: wait ran out", $time);
            stop_test();
        end
    endtask
    task automatic hiccup();
        vout_zero_i = 1'h1;
        cyc(1);
        vout_zero_i = 1'h0;
        wait_for(1'h0, HC + 10);
        check({7'h0, k >= HC - 2 && k <= HC + 3}, 8'h01);
    endtask
    task automatic pulse_event(ref logic ev);
        ev = 1'h1;
        cyc(1);
        ev = 1'h0;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        cyc(12);
        resetn_i = 1'h1;
        cyc(1);
        check(cfg_rdata_o, 8'h3F);
        check(fault_flag_n_o, 8'hFF);
        cfg_write(8'hA5, 1'h0);
        check(cfg_rdata_o, 8'hA5);
        pulse_event(tw);
        check({7'h0, warn}, 8'h01);
        check(fault_flag_n_o, 8'h7F);
        flag_clr_i = 8'h80;
        cfg_write(8'h3F, 1'h1);
        check(cfg_rdata_o, 8'h3F);
        $display("config test done");
        turn_on_i = 1'h1;
        wait_for(1'h0, 4);
        above_pb = 1'h1;
        uv = 1'h1;
        trk = 1'h1;
        cyc(2);
        uv = 1'h0;
        trk = 1'h0;
        check({7'h0, sw}, 8'h01);
        check(fault_flag_n_o, 8'hFF);
        pulse_event(done);
        cyc(1);
        check({6'h0, rup, sw}, 8'h01);
        $display("start test done");
        pulse_event(oc);
        check({5'h0, sw, low_side, oe}, 8'h01);
        check(fault_flag_n_o, 8'hF7);
        check({7'h0, line}, 8'h00);
        cyc(2);
        check({5'h0, other_lines}, 8'h00);
        hiccup();
        check({7'h0, oe}, 8'h00);
        pulse_event(done);
        flag_clr_i = 8'h08;
        cyc(1);
        flag_clr_i = 8'h00;
        check(fault_flag_n_o, 8'hFF);
        $display("fast fault test done");
        cfg_write(8'h3B, 1'h1);
        pulse_event(uv);
        check({6'h0, sw, oe}, 8'h02);
        cyc(4);
        check({7'h0, rdn}, 8'h00);
        wait_for(1'h1, 8);
        hiccup();
        $display("regular fault test done");
        peer_pull[7] = 1'h1;
        cyc(1);
        check({7'h0, sw}, 8'h01);
        wait_for(1'h1, 10);
        peer_pull[7] = 1'h0;
        hiccup();
        peer_err = 1'h1;
        peer_pull[30] = 1'h1;
        cyc(1);
        check({5'h0, sw, low_side, fe_off}, 8'h01);
        peer_pull[30] = 1'h0;
        peer_err = 1'h0;
        hiccup();
        $display("received event test done");
        pulse_event(ov);
        check({5'h0, sw, low_side, oe}, 8'h03);
        check(fault_flag_n_o, 8'hF9);
        hiccup();
        check({7'h0, low_side}, 8'h00);
        $display("error test done");
        stop_test();
    end
endmodule // fault_propagation_manager_bench

//--- dv/group_line_model.sv
// Purpose: group line with peer units and an external power manager
// Assumes: line has a pull-up; any party may pull it low
// Notes: three further lines stand for the manager's other groups
`timescale 1ns/100ps
module group_line_model #(
    parameter int N_PEERS = 31
) (
    input wire logic clk_sys_i,
    input wire logic dut_oe_i,
    input wire logic [N_PEERS-1:0] peer_pull_i,
    input wire logic peer_error_i,
    input wire logic fwd_en_i,
    output logic line_o,
    output logic error_o,
    output logic [2:0] other_lines_o,
    output logic front_end_off_o
);
    // wired-and of all pullers; a released line rises to the pull-up level
    assign line_o = !(dut_oe_i || (|peer_pull_i));
    assign error_o = peer_error_i && !line_o;
    // manager forwards a cycle late, as a real sampler would
    always_ff @(posedge clk_sys_i) begin
        other_lines_o <= (fwd_en_i && !line_o) ? 3'h0 : 3'h7;
        front_end_off_o <= error_o;
    end
endmodule // group_line_model

//--- hw/fault_prop_pkg.sv
// Purpose: shared constants for the group fault propagation block
// Assumes: controller clock of 20 MHz
// Notes: configuration bit positions follow the propagation configuration byte
package fault_prop_pkg;

    // ****************************************
    // configuration byte layout
    // ****************************************
    localparam int CFG_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h3F;
    localparam int BIT_PT = 7;
    localparam int BIT_PG = 6;
    localparam int BIT_TR = 5;
    localparam int BIT_OT = 4;
    localparam int BIT_OC = 3;
    localparam int BIT_UV = 2;
    localparam int BIT_OV = 1;
    localparam int BIT_PV = 0;

    // ****************************************
    // status flags, active low, same bit order
    // ****************************************
    localparam int FLAG_W = 8;
    localparam logic [7:0] FLAG_RESET = 8'hFF;

    // ****************************************
    // latching selection, one bit per protection
    // ****************************************
    localparam int LATCH_W = 5;
    localparam int LAT_TR = 4;
    localparam int LAT_OT = 3;
    localparam int LAT_OC = 2;
    localparam int LAT_UV = 1;
    localparam int LAT_OV = 0;

    // ****************************************
    // timing
    // ****************************************
    localparam longint CLK_HZ = 20000000;
    localparam longint HICCUP_MS = 130;
    localparam longint HICCUP_CYC = (HICCUP_MS * CLK_HZ) / 1000;
    localparam int TMR_W = 22;
    localparam logic [21:0] TMR_ZERO = 22'h000000;
    localparam logic [21:0] TMR_ONE = 22'h000001;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_RAMP_UP,
        ST_STEADY,
        ST_TOFF_WAIT,
        ST_RAMP_DOWN,
        ST_FAST_OFF,
        ST_HICCUP,
        ST_LATCHED
    } unit_state_t;

endpackage

//--- hw/fault_propagation_manager.sv
// Purpose: group fault line handling, turn-off style and hiccup restart
// Assumes: detector inputs are already qualified analog comparisons
// Notes: the group line is open-drain; the pad resolves the wired level
//
// Function
// [R1] works for groups of one to thirty-two
// [R2] faulty unit pulls group line when enabled
// [R3] low group line starts own turn-off
// [R4] eight-bit propagation config written by host
// [R5] manager serves up to four groups
// [R6] manager forwards low line to other groups
// [R7] manager may stop front end, fire crowbar
// [R8] propagated fault gives regular ramped turn-off
// [R9] detecting unit keeps its own turn-off style
// [R10] propagated error gives fast turn-off
// [R11] own error: fast off, low side on
// [R12] non-latching protection retries every 130ms
// [R13] hiccup timed from output zero to ramp
// [R14] regular off: delay, then falling slew
// [R15] unaffected unit keeps ramping to steady state
// [R16] per-protection responses; only tracking disableable
// [R17] arm protections by output phase
// [R18] latched unit restarts after 130ms and release
// [R19] each event clears its active-low flag
// [R20] group line driven open-drain only
`timescale 1ns/100ps
module fault_propagation_manager #(
    parameter int HICCUP_CYCLES = int'(fault_prop_pkg::HICCUP_CYC)
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_wdata_i,
    output logic [7:0] cfg_rdata_o,
    input wire logic [7:0] flag_clr_i,
    output logic [7:0] fault_flag_n_o,
    input wire logic [4:0] latch_sel_i,
    input wire logic track_en_i,
    input wire logic [21:0] toff_delay_cyc_i,
    input wire logic turn_on_i,
    input wire logic above_prebias_i,
    input wire logic ramp_up_done_i,
    input wire logic vout_zero_i,
    input wire logic temp_warn_i,
    input wire logic pgood_bad_i,
    input wire logic track_det_i,
    input wire logic overtemp_det_i,
    input wire logic overcurrent_det_i,
    input wire logic undervoltage_det_i,
    input wire logic overvoltage_det_i,
    input wire logic group_error_i,
    input wire logic group_fault_i,
    output logic group_fault_o,
    output logic group_fault_oe_o,
    output logic warn_report_o,
    output logic ramp_up_o,
    output logic ramp_down_o,
    output logic switching_en_o,
    output logic low_side_on_o
);

    // ****************************************
    // configuration byte
    // ****************************************
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;

    always_comb begin
        cfg_next = cfg_reg;
        if (cfg_wr_i) begin
            cfg_next = cfg_wdata_i; // [R4]
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_reg <= fault_prop_pkg::CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign cfg_rdata_o = cfg_reg;

    // ****************************************
    // protection arming and classification
    // ****************************************
    fault_prop_pkg::unit_state_t state_reg;
    fault_prop_pkg::unit_state_t state_next;
    logic running;
    logic arm_prebias;
    logic arm_steady;
    logic arm_ramp;
    logic ev_tr;
    logic ev_ot;
    logic ev_oc;
    logic ev_uv;
    logic ev_ov;
    logic ev_pg;
    logic ev_err;
    logic ev_fast;
    logic ev_reg;
    logic ev_any;
    logic prop_hit;
    logic own_latch;

    assign running = (state_reg == fault_prop_pkg::ST_RAMP_UP)
        || (state_reg == fault_prop_pkg::ST_STEADY);
    assign arm_prebias = running && above_prebias_i; // [R17]
    assign arm_steady = (state_reg == fault_prop_pkg::ST_STEADY); // [R17]
    // tracking is the only protection software may switch off
    assign arm_ramp = (state_reg == fault_prop_pkg::ST_RAMP_UP) && track_en_i; // [R17] [R16]

    assign ev_tr = arm_ramp && track_det_i;
    assign ev_ot = running && overtemp_det_i;
    assign ev_oc = arm_prebias && overcurrent_det_i;
    assign ev_uv = arm_steady && undervoltage_det_i && !overcurrent_det_i;
    assign ev_ov = arm_prebias && overvoltage_det_i;
    assign ev_pg = arm_steady && pgood_bad_i;

    // warnings never reach the turn-off path
    assign ev_err = ev_ov; // [R16]
    assign ev_fast = ev_tr || ev_oc; // [R16]
    assign ev_reg = ev_ot || ev_uv; // [R16]
    assign ev_any = ev_err || ev_fast || ev_reg;

    assign prop_hit = (ev_tr && cfg_reg[fault_prop_pkg::BIT_TR])
        || (ev_ot && cfg_reg[fault_prop_pkg::BIT_OT])
        || (ev_oc && cfg_reg[fault_prop_pkg::BIT_OC])
        || (ev_uv && cfg_reg[fault_prop_pkg::BIT_UV])
        || (ev_ov && cfg_reg[fault_prop_pkg::BIT_OV]); // [R2]

    assign own_latch = (ev_tr && latch_sel_i[fault_prop_pkg::LAT_TR])
        || (ev_ot && latch_sel_i[fault_prop_pkg::LAT_OT])
        || (ev_oc && latch_sel_i[fault_prop_pkg::LAT_OC])
        || (ev_uv && latch_sel_i[fault_prop_pkg::LAT_UV])
        || (ev_ov && latch_sel_i[fault_prop_pkg::LAT_OV]);

    // ****************************************
    // status flags
    // ****************************************
    logic [7:0] flag_set;

    always_comb begin
        flag_set = 8'h00;
        flag_set[fault_prop_pkg::BIT_PT] = temp_warn_i;
        flag_set[fault_prop_pkg::BIT_PG] = ev_pg;
        flag_set[fault_prop_pkg::BIT_TR] = ev_tr; // [R19]
        flag_set[fault_prop_pkg::BIT_OT] = ev_ot; // [R19]
        flag_set[fault_prop_pkg::BIT_OC] = ev_oc; // [R19]
        flag_set[fault_prop_pkg::BIT_UV] = ev_uv; // [R19]
        flag_set[fault_prop_pkg::BIT_OV] = ev_ov; // [R19]
    end

    flag_bank u_flags (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .set_i(flag_set),
        .clr_i(flag_clr_i),
        .flag_n_o(fault_flag_n_o)
    );

    // ****************************************
    // shared interval timer
    // ****************************************
    logic tmr_load;
    logic [21:0] tmr_val;
    logic tmr_expired;
    localparam logic [21:0] HICCUP_LOAD = HICCUP_CYCLES[21:0];

    interval_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .expired_o(tmr_expired)
    );

    // ****************************************
    // turn-off and restart sequencer
    // ****************************************
    logic drive_reg;
    logic drive_next;
    logic latch_reg;
    logic latch_next;
    logic ls_reg;
    logic ls_next;
    logic cycled_reg;
    logic cycled_next;
    logic [7:0] cause_reg;
    logic [7:0] cause_next;
    logic peer_off;
    logic released;

    // own pull-down is masked so a unit does not react to itself
    assign peer_off = !group_fault_i && !drive_reg; // [R3] [R1]
    assign released = ((fault_flag_n_o & cause_reg) == cause_reg)
        && !ev_any && !overtemp_det_i;
    localparam logic [7:0] FLAG_WARN_MASK = 8'hC0;

    always_comb begin
        state_next = state_reg;
        drive_next = drive_reg;
        latch_next = latch_reg;
        ls_next = ls_reg;
        cycled_next = cycled_reg;
        cause_next = cause_reg;
        tmr_load = 1'b0;
        tmr_val = HICCUP_LOAD;
        unique case (state_reg)
            fault_prop_pkg::ST_OFF: begin
                if (turn_on_i) begin
                    state_next = fault_prop_pkg::ST_RAMP_UP;
                end
            end
            fault_prop_pkg::ST_RAMP_UP,
            fault_prop_pkg::ST_STEADY: begin
                if (ev_any) begin
                    cause_next = flag_set & ~FLAG_WARN_MASK;
                    latch_next = own_latch;
                    drive_next = prop_hit; // [R2]
                    if (ev_err) begin
                        ls_next = 1'b1; // [R11]
                        state_next = fault_prop_pkg::ST_FAST_OFF;
                    end else if (ev_fast) begin
                        state_next = fault_prop_pkg::ST_FAST_OFF; // [R9]
                    end else begin
                        tmr_load = 1'b1;
                        tmr_val = toff_delay_cyc_i;
                        state_next = fault_prop_pkg::ST_TOFF_WAIT; // [R9]
                    end
                end else if (peer_off) begin
                    latch_next = 1'b0;
                    if (group_error_i) begin
                        state_next = fault_prop_pkg::ST_FAST_OFF; // [R10]
                    end else begin
                        tmr_load = 1'b1;
                        tmr_val = toff_delay_cyc_i;
                        state_next = fault_prop_pkg::ST_TOFF_WAIT; // [R8]
                    end
                end else if (!turn_on_i) begin
                    latch_next = 1'b0;
                    cause_next = 8'h00;
                    tmr_load = 1'b1;
                    tmr_val = toff_delay_cyc_i;
                    state_next = fault_prop_pkg::ST_TOFF_WAIT;
                end else if (state_reg == fault_prop_pkg::ST_RAMP_UP && ramp_up_done_i) begin
                    state_next = fault_prop_pkg::ST_STEADY; // [R15]
                end
            end
            fault_prop_pkg::ST_TOFF_WAIT: begin
                if (tmr_expired) begin
                    state_next = fault_prop_pkg::ST_RAMP_DOWN; // [R14]
                end
            end
            fault_prop_pkg::ST_RAMP_DOWN,
            fault_prop_pkg::ST_FAST_OFF: begin
                if (vout_zero_i) begin
                    tmr_load = 1'b1; // [R13]
                    tmr_val = HICCUP_LOAD;
                    cycled_next = 1'b0;
                    if (latch_reg) begin
                        state_next = fault_prop_pkg::ST_LATCHED; // [R18]
                    end else if (cause_reg == 8'h00 && !peer_off && !turn_on_i) begin
                        state_next = fault_prop_pkg::ST_OFF;
                    end else begin
                        state_next = fault_prop_pkg::ST_HICCUP; // [R12]
                    end
                end
            end
            fault_prop_pkg::ST_HICCUP: begin
                // the line is released here so peers restart in step
                drive_next = 1'b0;
                if (tmr_expired && !overtemp_det_i) begin
                    ls_next = 1'b0;
                    cause_next = 8'h00;
                    state_next = turn_on_i ? fault_prop_pkg::ST_RAMP_UP
                        : fault_prop_pkg::ST_OFF; // [R12]
                end
            end
            fault_prop_pkg::ST_LATCHED: begin
                drive_next = 1'b0;
                if (!turn_on_i) begin
                    cycled_next = 1'b1;
                end
                if (tmr_expired && (released || (cycled_reg && turn_on_i))) begin
                    ls_next = 1'b0;
                    latch_next = 1'b0;
                    cause_next = 8'h00;
                    state_next = fault_prop_pkg::ST_OFF; // [R18]
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= fault_prop_pkg::ST_OFF;
            drive_reg <= 1'b0;
            latch_reg <= 1'b0;
            ls_reg <= 1'b0;
            cycled_reg <= 1'b0;
            cause_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            drive_reg <= drive_next;
            latch_reg <= latch_next;
            ls_reg <= ls_next;
            cycled_reg <= cycled_next;
            cause_reg <= cause_next;
        end
    end

    // ****************************************
    // power stage commands and group line
    // ****************************************
    logic ramp_up_reg;
    logic ramp_dn_reg;
    logic sw_reg;
    logic warn_reg;
    logic ramp_up_next;
    logic ramp_dn_next;
    logic sw_next;
    logic warn_next;

    always_comb begin
        ramp_up_next = (state_next == fault_prop_pkg::ST_RAMP_UP);
        ramp_dn_next = (state_next == fault_prop_pkg::ST_RAMP_DOWN); // [R14]
        // fast off drops both switches in the same edge, except own error, which turns the low side on in that edge
        sw_next = (state_next == fault_prop_pkg::ST_RAMP_UP)
            || (state_next == fault_prop_pkg::ST_STEADY)
            || (state_next == fault_prop_pkg::ST_TOFF_WAIT)
            || (state_next == fault_prop_pkg::ST_RAMP_DOWN); // [R10] [R9]
        warn_next = (temp_warn_i && cfg_reg[fault_prop_pkg::BIT_PT])
            || (ev_pg && cfg_reg[fault_prop_pkg::BIT_PG]);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ramp_up_reg <= 1'b0;
            ramp_dn_reg <= 1'b0;
            sw_reg <= 1'b0;
            warn_reg <= 1'b0;
        end else begin
            ramp_up_reg <= ramp_up_next;
            ramp_dn_reg <= ramp_dn_next;
            sw_reg <= sw_next;
            warn_reg <= warn_next;
        end
    end

    assign ramp_up_o = ramp_up_reg;
    assign ramp_down_o = ramp_dn_reg;
    assign switching_en_o = sw_reg;
    assign low_side_on_o = ls_reg; // [R11]
    assign warn_report_o = warn_reg;
    // never drive high: any member or the manager may hold it low
    assign group_fault_o = 1'b0; // [R20]
    assign group_fault_oe_o = drive_reg; // [R20] [R2]

endmodule // fault_propagation_manager

//--- hw/flag_bank.sv
// Purpose: active-low status flags, set by events, restored by clear
// Assumes: set and clear are one-cycle or level requests
// Notes: an event in the clearing cycle keeps the flag low
`timescale 1ns/100ps
module flag_bank (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [7:0] set_i,
    input wire logic [7:0] clr_i,
    output logic [7:0] flag_n_o
);
    logic [7:0] flag_reg;
    logic [7:0] flag_next;

    genvar g;
    generate
        for (g = 0; g < fault_prop_pkg::FLAG_W; g++) begin : g_bit
            always_comb begin
                flag_next[g] = flag_reg[g];
                if (set_i[g]) begin
                    flag_next[g] = 1'b0;
                end else if (clr_i[g]) begin
                    flag_next[g] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_reg <= fault_prop_pkg::FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_n_o = flag_reg;
endmodule // flag_bank

//--- hw/interval_timer.sv
// Purpose: loadable down counter for delays and hiccup intervals
// Assumes: load has priority over counting
// Notes: expired_o is high while the count rests at zero and low in any cycle with load_i high
`timescale 1ns/100ps
module interval_timer (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic load_i,
    input wire logic [21:0] load_val_i,
    output logic expired_o
);
    logic [21:0] cnt_reg;
    logic [21:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load_i) begin
            cnt_next = load_val_i;
        end else if (cnt_reg != fault_prop_pkg::TMR_ZERO) begin
            cnt_next = cnt_reg - fault_prop_pkg::TMR_ONE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= fault_prop_pkg::TMR_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired_o = (cnt_reg == fault_prop_pkg::TMR_ZERO) && !load_i;
endmodule // interval_timer
